// *** rtl/pfs_pin_sync.sv ***
// pfs_pin_sync: two flip-flop synchroniser for the pin inputs.
// assumes pins are asynchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module pfs_pin_sync #(
  parameter int W = 24
) (
  input  wire logic           clk_sys,
  input  wire logic           rst,
  pfs_sync_if.sync_side       port
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } pfs_sync_state_type;

  pfs_sync_state_type s_q;
  pfs_sync_state_type s_d;

  // ==========================================================
  // stage one feeds only stage two
  always_comb begin
    s_d        = s_q;
    s_d.stage1 = port.raw;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.sync = s_q.stage2;

endmodule
`default_nettype wire

// *** rtl/pfs_pkg.sv ***
// pfs_pkg: constants for the port pin function select block.
// assumes an 8-bit register port with 10-bit byte offsets.
package pfs_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NPIN   = 24;
  localparam int NTA    = 3;
  localparam int NIRQ   = 3;

  // ==========================================================
  // register offsets
  localparam logic [9:0] OFS_PORT7_DIR   = 10'h3ef;
  localparam logic [9:0] OFS_PORT8_DIR   = 10'h3f2;
  localparam logic [9:0] OFS_PORT9_DIR   = 10'h3f3;
  localparam logic [9:0] OFS_PULLUP7     = 10'h3fd;
  localparam logic [9:0] OFS_PULLUP89    = 10'h3fe;
  localparam logic [9:0] OFS_PORT7_DATA  = 10'h3c0;
  localparam logic [9:0] OFS_PORT8_DATA  = 10'h3c1;
  localparam logic [9:0] OFS_PORT9_DATA  = 10'h3c2;
  localparam logic [9:0] OFS_TMR_MODE    = 10'h3c3;
  localparam logic [9:0] OFS_TRIG_SEL    = 10'h3c4;
  localparam logic [9:0] OFS_TWO_PHASE   = 10'h3c5;
  localparam logic [9:0] OFS_MISC        = 10'h3c6;
  localparam logic [9:0] OFS_IRQ_STAT    = 10'h3c7;
  localparam logic [9:0] OFS_IRQ_MASK    = 10'h3c8;

  // ==========================================================
  // reset values and writable bit masks
  localparam logic [7:0] DIR_RST    = 8'h00;
  localparam logic [7:0] PU_RST     = 8'h00;
  localparam logic [7:0] LAT_RST    = 8'h00;
  localparam logic [7:0] SEL_RST    = 8'h00;
  localparam logic [2:0] IRQ_RST    = 3'h0;
  localparam logic [7:0] PU7_MASK   = 8'hc0;
  localparam logic [7:0] PU89_MASK  = 8'h0f;
  localparam logic [7:0] TMR_MASK   = 8'h3f;
  localparam logic [7:0] TRIG_MASK  = 8'hfc;
  localparam logic [7:0] TWOPH_MASK = 8'he0;
  localparam logic [7:0] MISC_MASK  = 8'h1f;

  // ==========================================================
  // field positions
  localparam int MODE_PULSE_POS = 0;
  localparam int MODE_GATE_POS  = 1;
  localparam int TRIG_BASE      = 2;
  localparam int TWOPH_BASE     = 5;
  localparam int MISC_THREE_PH  = 0;
  localparam int MISC_SUB_OSC   = 1;
  localparam int MISC_TB0_EVT   = 2;
  localparam int MISC_SIO3_SEL  = 3;
  localparam int MISC_SIO3_INT  = 4;
  localparam int PU7_FIRST_BIT  = 6;
  localparam int PINS_PER_PU    = 4;

  // ==========================================================
  // pin indices: port7 0..7, port8 8..15, port9 16..23
  localparam int TA_OUT_PIN [NTA]  = '{4, 6, 8};
  localparam int TA_IN_PIN  [NTA]  = '{5, 7, 9};
  localparam bit TA_HAS_3PH [NTA]  = '{1'b1, 1'b0, 1'b1};
  localparam int IRQ_PIN    [NIRQ] = '{10, 11, 12};
  localparam int PIN_SUB_OUT = 14;
  localparam int PIN_SUB_IN  = 15;
  localparam int PIN_SCLK3   = 16;

endpackage

// *** rtl/pfs_port_select.sv ***
// pfs_port_select: pin function select for ports 7, 8 and 9.
// assumes a one-cycle register port and asynchronous pin inputs.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module pfs_port_select (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  input  wire logic [23:0] pin_in,
  output logic      [23:0] pin_out,
  output logic      [23:0] pin_oe,
  output logic      [23:0] pin_pullup_en,
  input  wire logic       timer_a_ch2_output,
  input  wire logic       timer_a_ch3_output,
  input  wire logic       timer_a_ch4_output,
  output logic            timer_a_ch2_input,
  output logic            timer_a_ch3_input,
  output logic            timer_a_ch4_input,
  output logic      [2:0] timer_a_output_sense,
  output logic      [2:0] timer_a_gate_valid,
  output logic      [2:0] timer_a_two_phase_valid,
  input  wire logic       motor_phase_u,
  input  wire logic       motor_phase_u_n,
  input  wire logic       motor_phase_w,
  input  wire logic       motor_phase_w_n,
  output logic            timer_b_ch0_input,
  input  wire logic       sync_serial3_clock_out,
  output logic            sync_serial3_clock,
  output logic            sub_osc_enable,
  output logic            ext_irq_in_0,
  output logic            ext_irq_in_1,
  output logic            ext_irq_in_2
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  dir7;
    logic [7:0]  dir8;
    logic [7:0]  dir9;
    logic [7:0]  pu7;
    logic [7:0]  pu89;
    logic [7:0]  lat7;
    logic [7:0]  lat8;
    logic [7:0]  lat9;
    logic [7:0]  tmode;
    logic [7:0]  trig;
    logic [7:0]  twoph;
    logic [7:0]  misc;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
    logic [23:0] pins_prev;
    logic [7:0]  rdata;
    logic [23:0] pout;
    logic [23:0] poe;
    logic [23:0] ppu;
    logic [2:0]  ta_in;
    logic [2:0]  ta_sense;
    logic [2:0]  gate_ok;
    logic [2:0]  twoph_ok;
    logic        tb0;
    logic        sclk_in;
    logic        xc;
    logic [2:0]  ext;
    logic [2:0]  warm;
  } pfs_state_type;

  localparam pfs_state_type ST_RST = '{
    dir7:     pfs_pkg::DIR_RST,
    dir8:     pfs_pkg::DIR_RST,
    dir9:     pfs_pkg::DIR_RST,
    pu7:      pfs_pkg::PU_RST,
    pu89:     pfs_pkg::PU_RST,
    lat7:     pfs_pkg::LAT_RST,
    lat8:     pfs_pkg::LAT_RST,
    lat9:     pfs_pkg::LAT_RST,
    tmode:    pfs_pkg::SEL_RST,
    trig:     pfs_pkg::SEL_RST,
    twoph:    pfs_pkg::SEL_RST,
    misc:     pfs_pkg::SEL_RST,
    irq_st:   pfs_pkg::IRQ_RST,
    irq_mask: pfs_pkg::IRQ_RST,
    default:  '0
  };

  pfs_state_type s_q;
  pfs_state_type s_d;

  // ==========================================================
  // pin synchroniser
  pfs_sync_if #(.W(pfs_pkg::NPIN)) sync_bus ();

  assign sync_bus.raw = pin_in;

  pfs_pin_sync #(
    .W (pfs_pkg::NPIN)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (sync_bus.sync_side)
  );

  logic [23:0] pins;
  assign pins = sync_bus.sync;

  // ==========================================================
  // helpers

  // port read: latch where output, pin level where input
  function automatic logic [7:0] port_view(
    input logic [7:0] dir,
    input logic [7:0] lat,
    input logic [7:0] lvl
  );
    port_view = (dir & lat) | (~dir & lvl);
  endfunction

  // pull-up group bit for one pin index
  function automatic logic pu_group(
    input logic [7:0] pu7,
    input logic [7:0] pu89,
    input int         idx
  );
    logic [5:0] grp;
    grp = {pu89[3:0], pu7[pfs_pkg::PU7_FIRST_BIT +: 2]};
    pu_group = grp[idx / pfs_pkg::PINS_PER_PU];
  endfunction

  // ==========================================================
  // next state
  logic [23:0] dir_all;
  logic [23:0] lat_all;
  logic [2:0]  ta_pulse;
  logic [2:0]  ph_hi;
  logic [2:0]  ph_lo;

  assign dir_all  = {s_q.dir9, s_q.dir8, s_q.dir7};
  assign lat_all  = {s_q.lat9, s_q.lat8, s_q.lat7};
  assign ta_pulse = {timer_a_ch4_output, timer_a_ch3_output,
                     timer_a_ch2_output};
  assign ph_hi    = {motor_phase_u, 1'b0, motor_phase_w};
  assign ph_lo    = {motor_phase_u_n, 1'b0, motor_phase_w_n};

  always_comb begin
    logic [23:0] oe;
    logic [23:0] out;
    logic [2:0]  irq_ev;
    logic        three;
    logic        m_pulse;
    logic        m_gate;
    logic        tp;
    logic        tw;
    logic [1:0]  tsel;
    logic        sio_sel;
    logic        sio_int;
    int          op;
    int          ip;
    oe      = '0;
    out     = '0;
    irq_ev  = '0;
    three   = 1'b0;
    m_pulse = 1'b0;
    m_gate  = 1'b0;
    tp      = 1'b0;
    tw      = 1'b0;
    tsel    = '0;
    sio_sel = 1'b0;
    sio_int = 1'b0;
    op      = 0;
    ip      = 0;
    s_d       = s_q;
    s_d.rdata = '0;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        pfs_pkg::OFS_PORT7_DIR:  s_d.dir7 = reg_wdata;
        pfs_pkg::OFS_PORT8_DIR:  s_d.dir8 = reg_wdata;
        pfs_pkg::OFS_PORT9_DIR:  s_d.dir9 = reg_wdata;
        pfs_pkg::OFS_PULLUP7:    s_d.pu7 = reg_wdata & pfs_pkg::PU7_MASK;
        pfs_pkg::OFS_PULLUP89:   s_d.pu89 = reg_wdata & pfs_pkg::PU89_MASK;
        pfs_pkg::OFS_PORT7_DATA: s_d.lat7 = reg_wdata;
        pfs_pkg::OFS_PORT8_DATA: s_d.lat8 = reg_wdata;
        pfs_pkg::OFS_PORT9_DATA: s_d.lat9 = reg_wdata;
        pfs_pkg::OFS_TMR_MODE:   s_d.tmode = reg_wdata & pfs_pkg::TMR_MASK;
        pfs_pkg::OFS_TRIG_SEL:   s_d.trig = reg_wdata & pfs_pkg::TRIG_MASK;
        pfs_pkg::OFS_TWO_PHASE:
          s_d.twoph = reg_wdata & pfs_pkg::TWOPH_MASK;
        pfs_pkg::OFS_MISC:       s_d.misc = reg_wdata & pfs_pkg::MISC_MASK;
        pfs_pkg::OFS_IRQ_STAT:   s_d.irq_st = s_q.irq_st & ~reg_wdata[2:0];
        pfs_pkg::OFS_IRQ_MASK:   s_d.irq_mask = reg_wdata[2:0];
        default: ;
      endcase
    end

    // register reads, unmapped reads give zero
    if (reg_rd) begin
      case (reg_addr)
        pfs_pkg::OFS_PORT7_DIR:  s_d.rdata = s_q.dir7;
        pfs_pkg::OFS_PORT8_DIR:  s_d.rdata = s_q.dir8;
        pfs_pkg::OFS_PORT9_DIR:  s_d.rdata = s_q.dir9;
        pfs_pkg::OFS_PULLUP7:    s_d.rdata = s_q.pu7;
        pfs_pkg::OFS_PULLUP89:   s_d.rdata = s_q.pu89;
        pfs_pkg::OFS_PORT7_DATA:
          s_d.rdata = port_view(s_q.dir7, s_q.lat7, pins[7:0]);
        pfs_pkg::OFS_PORT8_DATA:
          s_d.rdata = port_view(s_q.dir8, s_q.lat8, pins[15:8]);
        pfs_pkg::OFS_PORT9_DATA:
          s_d.rdata = port_view(s_q.dir9, s_q.lat9, pins[23:16]);
        pfs_pkg::OFS_TMR_MODE:   s_d.rdata = s_q.tmode;
        pfs_pkg::OFS_TRIG_SEL:   s_d.rdata = s_q.trig;
        pfs_pkg::OFS_TWO_PHASE:  s_d.rdata = s_q.twoph;
        pfs_pkg::OFS_MISC:       s_d.rdata = s_q.misc;
        pfs_pkg::OFS_IRQ_STAT:   s_d.rdata = {5'h00, s_q.irq_st};
        pfs_pkg::OFS_IRQ_MASK:   s_d.rdata = {5'h00, s_q.irq_mask};
        default:                 s_d.rdata = '0;
      endcase
    end

    // plain port behaviour
    oe  = dir_all;
    out = lat_all;

    // timer A channels 2, 3, 4
    three = s_q.misc[pfs_pkg::MISC_THREE_PH];
    for (int c = 0; c < pfs_pkg::NTA; c++) begin
      op      = pfs_pkg::TA_OUT_PIN[c];
      ip      = pfs_pkg::TA_IN_PIN[c];
      m_pulse = s_q.tmode[2 * c + pfs_pkg::MODE_PULSE_POS];
      m_gate  = s_q.tmode[2 * c + pfs_pkg::MODE_GATE_POS];
      tsel    = s_q.trig[pfs_pkg::TRIG_BASE + 2 * c +: 2];
      tw      = s_q.twoph[pfs_pkg::TWOPH_BASE + c];
      tp      = three & pfs_pkg::TA_HAS_3PH[c];
      if (tp) begin
        oe[op]  = 1'b1;
        out[op] = ph_hi[c];
        oe[ip]  = 1'b1;
        out[ip] = ph_lo[c];
      end else if (tw) begin
        oe[op]  = 1'b0;
      end else if (m_pulse) begin
        oe[op]  = 1'b1;
        out[op] = ta_pulse[c];
      end
      s_d.ta_sense[c] = pins[op] & ~dir_all[op] & m_gate & ~m_pulse & ~tp;
      s_d.twoph_ok[c] = ~dir_all[op] & m_gate & ~m_pulse & tw
                        & ~tp;
      s_d.ta_in[c]    = pins[ip] & ~dir_all[ip] & (tsel == 2'b00) & ~tp;
      s_d.gate_ok[c]  = ~dir_all[ip] & (tsel == 2'b00) & m_gate
                        & ~tp;
    end

    // timer B0 and serial 3 clock share one pin
    sio_sel = s_q.misc[pfs_pkg::MISC_SIO3_SEL];
    sio_int = s_q.misc[pfs_pkg::MISC_SIO3_INT];
    if (sio_sel && sio_int) begin
      oe[pfs_pkg::PIN_SCLK3]  = 1'b1;
      out[pfs_pkg::PIN_SCLK3] = sync_serial3_clock_out;
    end
    s_d.tb0 = pins[pfs_pkg::PIN_SCLK3] & ~dir_all[pfs_pkg::PIN_SCLK3]
              & ~s_q.misc[pfs_pkg::MISC_TB0_EVT] & ~sio_sel;
    s_d.sclk_in = pins[pfs_pkg::PIN_SCLK3] & ~dir_all[pfs_pkg::PIN_SCLK3]
                  & sio_sel & ~sio_int;

    // sub-clock oscillator owns its two pins
    s_d.xc = s_q.misc[pfs_pkg::MISC_SUB_OSC];
    if (s_d.xc) begin
      oe[pfs_pkg::PIN_SUB_IN]  = 1'b0;
      oe[pfs_pkg::PIN_SUB_OUT] = 1'b0;
    end

    // pull-ups follow their group and only on inputs
    for (int i = 0; i < pfs_pkg::NPIN; i++) begin
      s_d.ppu[i] = pu_group(s_q.pu7, s_q.pu89, i) & ~oe[i];
    end
    if (s_d.xc) begin
      s_d.ppu[pfs_pkg::PIN_SUB_IN]  = 1'b0;
      s_d.ppu[pfs_pkg::PIN_SUB_OUT] = 1'b0;
    end
    s_d.pout = out;
    s_d.poe  = oe;

    // external interrupt pins: any level change on an input pin
    for (int k = 0; k < pfs_pkg::NIRQ; k++) begin
      s_d.ext[k] = pins[pfs_pkg::IRQ_PIN[k]]
                   & ~dir_all[pfs_pkg::IRQ_PIN[k]];
      irq_ev[k]  = (pins[pfs_pkg::IRQ_PIN[k]]
                    ^ s_q.pins_prev[pfs_pkg::IRQ_PIN[k]])
                   & ~dir_all[pfs_pkg::IRQ_PIN[k]];
    end
    // no events until synchroniser and history hold real pin levels
    if (!s_q.warm[2]) begin
      irq_ev = '0;
    end
    s_d.warm      = {s_q.warm[1:0], 1'b1};
    s_d.pins_prev = pins;
    // a new event wins over a clear in the same cycle
    s_d.irq_st = s_d.irq_st | irq_ev;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata               = s_q.rdata;
  assign irq                     = |(s_q.irq_st & s_q.irq_mask);
  assign pin_out                 = s_q.pout;
  assign pin_oe                  = s_q.poe;
  assign pin_pullup_en           = s_q.ppu;
  assign timer_a_ch2_input       = s_q.ta_in[0];
  assign timer_a_ch3_input       = s_q.ta_in[1];
  assign timer_a_ch4_input       = s_q.ta_in[2];
  assign timer_a_output_sense    = s_q.ta_sense;
  assign timer_a_gate_valid      = s_q.gate_ok;
  assign timer_a_two_phase_valid = s_q.twoph_ok;
  assign timer_b_ch0_input       = s_q.tb0;
  assign sync_serial3_clock      = s_q.sclk_in;
  assign sub_osc_enable          = s_q.xc;
  assign ext_irq_in_0            = s_q.ext[0];
  assign ext_irq_in_1            = s_q.ext[1];
  assign ext_irq_in_2            = s_q.ext[2];

endmodule
`default_nettype wire

// *** rtl/pfs_sync_if.sv ***
// pfs_sync_if: raw pin levels in, synchronised levels out.
// assumes both ends run on clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface pfs_sync_if #(
  parameter int W = 24
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// *** testbench/pfs_board_model.sv ***
// pfs_board_model: board side of the port pins.
// assumes the bench says which pins an outside source drives.
`timescale 1ns/100ps
`default_nettype none
module pfs_board_model (
  input  wire logic        clk_sys,
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pin_pullup_en,
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] ext_val,
  output logic      [23:0] pin_in
);
  // ==========================================================
  // pin level
  logic [23:0] float_q = 24'h00_0000;
  // a floating pin keeps no value: it changes every cycle
  always @(posedge clk_sys) float_q <= ~float_q;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pullup_en | float_q));
endmodule
`default_nettype wire

// *** testbench/pfs_port_select_monitor.sv ***
// pfs_port_select_monitor: assertions on the pin select ports.
// assumes one clock domain and a synchronous active high reset.
`timescale 1ns/100ps
`default_nettype none
module pfs_port_select_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [9:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        irq,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pullup_en,
  input wire logic        motor_phase_u,
  input wire logic        motor_phase_w,
  input wire logic [2:0]  timer_a_gate_valid,
  input wire logic [2:0]  timer_a_two_phase_valid,
  input wire logic        ext_irq_in_0
);
  // ==========================================================
  // shadow of the port 8 direction, port 8/9 pull-up, timer and misc control registers
  logic [7:0] d8_q, pu_q, tm_q, ts_q, tp_q, ms_q;
  logic       tpv, gv, tps;
  logic [1:0] pux;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {d8_q, pu_q, tm_q, ts_q, tp_q, ms_q} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        pfs_pkg::OFS_PORT8_DIR: d8_q <= reg_wdata;
        pfs_pkg::OFS_PULLUP89:  pu_q <= reg_wdata;
        pfs_pkg::OFS_TMR_MODE:  tm_q <= reg_wdata;
        pfs_pkg::OFS_TRIG_SEL:  ts_q <= reg_wdata;
        pfs_pkg::OFS_TWO_PHASE: tp_q <= reg_wdata;
        pfs_pkg::OFS_MISC:      ms_q <= reg_wdata;
        default: ;
      endcase
    end
  end
  assign tpv = !d8_q[0] && tm_q[5] && !tm_q[4] && tp_q[7] && !ms_q[0];
  assign gv = !d8_q[1] && ts_q[7:6] == 2'h0 && tm_q[5] && !ms_q[0];
  assign tps = tp_q[7] && !ms_q[0];
  assign pux = {2{pu_q[1]}} & ~d8_q[5:4];
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rdata_idle;
    reg_rdata != 8'h00 |-> $past(reg_rd);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_plain_oe;
    pin_oe[13:10] == $past(d8_q[5:2]);
  endproperty
  a_plain_oe: assert property (p_plain_oe)
    else $error("pin enable differs from direction");
  property p_pullup;
    pin_pullup_en[13:12] == $past(pux);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable wrong");
  property p_irq_lvl;
    ext_irq_in_0 |-> !pin_oe[10] && $past(pin_in[10], 3);
  endproperty
  a_irq_lvl: assert property (p_irq_lvl)
    else $error("interrupt input level wrong");
  property p_irq_rise;
    $rose(irq) |-> $past(reg_wr)
      || $past(pin_in[12:10], 2) != $past(pin_in[12:10], 3)
      || $past(pin_in[12:10], 3) != $past(pin_in[12:10], 4)
      || $past(pin_in[12:10], 4) != $past(pin_in[12:10], 5);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt without pin change");
  property p_two_phase;
    timer_a_two_phase_valid[2] == $past(tpv);
  endproperty
  a_two_phase: assert property (p_two_phase)
    else $error("two-phase accept wrong");
  property p_two_ph_oe;
    $past(tps) |-> !pin_oe[8];
  endproperty
  a_two_ph_oe: assert property (p_two_ph_oe)
    else $error("two-phase pin still drives");
  property p_gate;
    timer_a_gate_valid[2] == $past(gv);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate input accept wrong");
  property p_three_oe;
    $past(ms_q[0]) |-> &{pin_oe[9:8], pin_oe[5:4]};
  endproperty
  a_three_oe: assert property (p_three_oe)
    else $error("phase pins not driven");
  property p_three_out;
    $past(ms_q[0]) |-> pin_out[8] == $past(motor_phase_u)
      && pin_out[4] == $past(motor_phase_w);
  endproperty
  a_three_out: assert property (p_three_out)
    else $error("phase pin value wrong");
endmodule
bind pfs_port_select pfs_port_select_monitor u_mon (
  .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .irq, .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .motor_phase_u,
  .motor_phase_w, .timer_a_gate_valid, .timer_a_two_phase_valid,
  .ext_irq_in_0
);
`default_nettype wire

// *** testbench/testbench.sv ***
// testbench: register driven checks of the port pin select block.
// assumes the board model closes the loop from pin drive to pin level.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys, rst, reg_wr, reg_rd, irq, sub_osc_enable;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [23:0] pin_in, pin_out, pin_oe, pin_pullup_en, ext_en, ext_val;
  logic [2:0]  ta_o, timer_a_output_sense, timer_a_gate_valid;
  logic [2:0]  timer_a_two_phase_valid;
  logic [2:0]  ta_i;
  logic        timer_a_ch2_input, timer_a_ch3_input, timer_a_ch4_input;
  logic        motor_phase_u, motor_phase_u_n, motor_phase_w;
  logic        motor_phase_w_n, timer_b_ch0_input;
  logic        sync_serial3_clock_out, sync_serial3_clock;
  logic        ext_irq_in_0, ext_irq_in_1, ext_irq_in_2;
  int          n_mismatch, checks_done, cyc;
  logic [9:0]  ra [5];
  logic [7:0]  rm [5];
  pfs_port_select u_pfs_port_select (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .pin_in, .pin_out, .pin_oe, .pin_pullup_en,
    .timer_a_ch2_output(ta_o[0]), .timer_a_ch3_output(ta_o[1]),
    .timer_a_ch4_output(ta_o[2]), .timer_a_ch2_input, .timer_a_ch3_input,
    .timer_a_ch4_input, .timer_a_output_sense, .timer_a_gate_valid,
    .timer_a_two_phase_valid, .motor_phase_u, .motor_phase_u_n,
    .motor_phase_w, .motor_phase_w_n, .timer_b_ch0_input,
    .sync_serial3_clock_out, .sync_serial3_clock, .sub_osc_enable,
    .ext_irq_in_0, .ext_irq_in_1, .ext_irq_in_2
  );
  pfs_board_model u_pfs_board_model (
    .clk_sys, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pin_in
  );
  assign ta_i = {timer_a_ch4_input, timer_a_ch3_input, timer_a_ch2_input};
  // ==========================================================
  // tasks
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string s, input logic [23:0] e,
                     input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input string s);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(s, e, reg_rdata);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ==========================================================
  // tests
  initial begin
    {clk_sys, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {motor_phase_u, motor_phase_u_n, motor_phase_w, motor_phase_w_n} = '0;
    {rst, ta_o, sync_serial3_clock_out} = 5'h1d;
    ext_en = 24'hff_ffff;
    ext_val = 24'h00_0000;
    ra = '{pfs_pkg::OFS_PORT7_DIR, pfs_pkg::OFS_PORT8_DIR,
      pfs_pkg::OFS_PORT9_DIR, pfs_pkg::OFS_PULLUP7, pfs_pkg::OFS_PULLUP89};
    rm = '{8'hff, 8'hff, 8'hff, pfs_pkg::PU7_MASK, pfs_pkg::PU89_MASK};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ra[i], 8'h00, "reset value");
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], 8'hff);
      rd(ra[i], rm[i], "writable bits");
      wr(ra[i], 8'h00);
    end
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00, "unmapped");
    // plain port use and pull-ups
    wr(pfs_pkg::OFS_PORT8_DATA, 8'ha5);
    wr(pfs_pkg::OFS_PORT8_DIR, 8'h30);
    wr(pfs_pkg::OFS_PULLUP89, 8'h02);
    idle(2);
    chk("enable", 24'h00_3000, pin_oe);
    chk("drive", 2'h2, pin_out[13:12]);
    chk("pull-up", 24'h00_c000, pin_pullup_en);
    ext_val <= 24'h00_0f00;
    idle(3);
    rd(pfs_pkg::OFS_PORT8_DATA, 8'h2f, "port read");
    ext_val <= 24'h00_0000;
    wr(pfs_pkg::OFS_PORT8_DIR, 8'h00);
    wr(pfs_pkg::OFS_PULLUP7, 8'hc0);
    idle(2);
    chk("pull-up all", 24'h00_f0ff, pin_pullup_en);
    chk("enable off", 24'h00_0000, pin_oe);
    wr(pfs_pkg::OFS_PULLUP7, 8'h00);
    wr(pfs_pkg::OFS_PULLUP89, 8'h00);
    // pin change events
    wr(pfs_pkg::OFS_IRQ_STAT, 8'h07);
    wr(pfs_pkg::OFS_IRQ_MASK, 8'h01);
    idle(1);
    chk("irq idle", 1'b0, irq);
    ext_val[10] <= 1'b1;
    idle(6);
    chk("irq", 1'b1, irq);
    chk("irq line", 1'b1, ext_irq_in_0);
    ext_val[11] <= 1'b1;
    idle(6);
    chk("irq line 1", 1'b1, ext_irq_in_1);
    rd(pfs_pkg::OFS_IRQ_STAT, 8'h03, "status");
    wr(pfs_pkg::OFS_IRQ_STAT, 8'h03);
    idle(1);
    chk("irq cleared", 1'b0, irq);
    wr(pfs_pkg::OFS_PORT8_DIR, 8'h10);
    wr(pfs_pkg::OFS_PORT8_DATA, 8'hb5);
    idle(6);
    rd(pfs_pkg::OFS_IRQ_STAT, 8'h00, "output pin event");
    chk("irq line out", 1'b0, ext_irq_in_2);
    wr(pfs_pkg::OFS_PORT8_DIR, 8'h00);
    ext_val[9:4] <= 6'h3f;
    // timer pins, every channel
    for (int c = 0; c < 3; c++) begin
      wr(pfs_pkg::OFS_TMR_MODE, 8'h02 << (2 * c));
      wr(pfs_pkg::OFS_TWO_PHASE, 8'h20 << c);
      idle(2);
      chk("two-phase", 3'h1 << c, timer_a_two_phase_valid);
      chk("gate", 3'h1 << c, timer_a_gate_valid);
      chk("sense", 3'h1 << c, timer_a_output_sense);
      chk("timer in", 3'h7, ta_i);
      wr(pfs_pkg::OFS_TRIG_SEL, 8'h04 << (2 * c));
      wr(pfs_pkg::OFS_TMR_MODE, 8'h03 << (2 * c));
      idle(2);
      chk("trigger", 3'h0, timer_a_gate_valid);
      chk("trig in", 3'h7 ^ (3'h1 << c), ta_i);
      chk("pulse mode", 3'h0, timer_a_two_phase_valid);
      chk("pin input", 1'b0, pin_oe[pfs_pkg::TA_OUT_PIN[c]]);
      wr(pfs_pkg::OFS_TWO_PHASE, 8'h00);
      wr(pfs_pkg::OFS_TRIG_SEL, 8'h00);
      idle(2);
      chk("pulse", {1'b1, ta_o[c]}, {pin_oe[pfs_pkg::TA_OUT_PIN[c]],
        pin_out[pfs_pkg::TA_OUT_PIN[c]]});
    end
    wr(pfs_pkg::OFS_TMR_MODE, 8'h20);
    ext_val[9] <= 1'b1;
    idle(4);
    chk("gate level", 1'b1, timer_a_ch4_input);
    // three-phase override
    {motor_phase_u, motor_phase_u_n, motor_phase_w, motor_phase_w_n} <= 4'h9;
    wr(pfs_pkg::OFS_TWO_PHASE, 8'he0);
    wr(pfs_pkg::OFS_MISC, 8'h01);
    idle(2);
    chk("phase enable", 4'hf, {pin_oe[9:8], pin_oe[5:4]});
    chk("phase drive", 4'h6, {pin_out[9:8], pin_out[5:4]});
    chk("no two-phase", 3'h0, timer_a_two_phase_valid);
    chk("no gate", 3'h0, timer_a_gate_valid & 3'h4);
    chk("phase in", 3'h2, ta_i);
    // shared serial pin and sub oscillator
    ext_val[16] <= 1'b1;
    wr(pfs_pkg::OFS_MISC, 8'h00);
    wr(pfs_pkg::OFS_PULLUP89, 8'h02);
    idle(4);
    chk("tb0 in", 2'h2, {timer_b_ch0_input, sync_serial3_clock});
    wr(pfs_pkg::OFS_MISC, 8'h0a);
    idle(2);
    chk("clk in", 2'h1, {timer_b_ch0_input, sync_serial3_clock});
    chk("sub osc", 24'h00_3000, pin_pullup_en);
    chk("sub osc on", 1'b1, sub_osc_enable);
    wr(pfs_pkg::OFS_MISC, 8'h18);
    idle(2);
    chk("serial clock", 4'hc, {pin_oe[16], pin_out[16], sync_serial3_clock,
      sub_osc_enable});
    final_report();
  end
endmodule
`default_nettype wire
